// File: src/vdisp_cmd_unit.sv
// command unit of a storage-tube vector display: ready flag, its timing,
// skip tests, converter load and comparator source select.
// assumes a classic wishbone master, an asynchronous erase pushbutton and
// an asynchronous comparator result from the analog side.
//
// The register offsets and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps

module vdisp_cmd_unit #(
	parameter int unsigned XY_CYC = vdisp_cmd_pkg::XY_CYCLES,
	parameter int unsigned SHORT_CYC = vdisp_cmd_pkg::SHORT_CYCLES,
	parameter int unsigned LONG_CYC = vdisp_cmd_pkg::LONG_CYCLES,
	parameter int unsigned ERASE_CYC = vdisp_cmd_pkg::ERASE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// display unit pins
	input wire logic erase_btn_i,
	input wire logic cmp_gt_i,
	output logic ready_irq_o,
	output logic [2:0] src_sel_o,
	output logic [9:0] dac_o,
	output logic [9:0] x_hold_o,
	output logic [9:0] y_hold_o,
	output logic [11:0] exec_param_o,
	output logic exec_start_o
);

	// ************************************************************
	// elaboration checks
	// ************************************************************
	if (XY_CYC < 2 || SHORT_CYC < 2 || LONG_CYC < 2 || ERASE_CYC < 2 ||
		ERASE_CYC >= (1 << vdisp_cmd_pkg::CNT_W) ||
		LONG_CYC >= (1 << vdisp_cmd_pkg::CNT_W)) begin : g_bad_cyc
		$error("completion delay out of counter range");
	end

	// delay for one execute kind
	function automatic vdisp_cmd_pkg::cnt_t kind_cycles(input logic [1:0] kind);
		vdisp_cmd_pkg::cnt_t c;
		c = vdisp_cmd_pkg::cnt_t'(vdisp_cmd_pkg::POINT_CYCLES);
		case (kind)
			vdisp_cmd_pkg::KIND_SHORT: c = vdisp_cmd_pkg::cnt_t'(SHORT_CYC);
			vdisp_cmd_pkg::KIND_LONG: c = vdisp_cmd_pkg::cnt_t'(LONG_CYC);
			vdisp_cmd_pkg::KIND_ERASE: c = vdisp_cmd_pkg::cnt_t'(ERASE_CYC);
			default: c = vdisp_cmd_pkg::cnt_t'(vdisp_cmd_pkg::POINT_CYCLES);
		endcase
		return c;
	endfunction : kind_cycles

	// ************************************************************
	// bus decode
	// ************************************************************
	logic req;
	logic wr_ok;
	logic [11:0] acc;
	logic do_sel, do_ldx, do_ldy, do_exec, do_clr, do_lda;
	logic start;

	// a request is taken once; ack blocks a second take at the answer edge
	assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	// accumulator spans lanes 0 and 1, a partial write is ignored
	assign wr_ok = req & wb_we_i & (wb_sel_i[1:0] == 2'b11);
	assign acc = wb_dat_i[11:0];
	// writes to read or unmapped offsets match no strobe and are only acked
	assign do_sel = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_SELECT_SRC);
	assign do_ldx = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_LOAD_X);
	assign do_ldy = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_LOAD_Y);
	assign do_exec = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_EXECUTE);
	assign do_clr = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_CLEAR_READY);
	assign do_lda = wr_ok & (wb_adr_i == vdisp_cmd_pkg::OFF_LOAD_CONV);
	assign start = do_ldx | do_ldy | do_exec;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	logic erase_m_q, erase_s_q, erase_d_q;
	logic cmp_m_q, cmp_s_q;
	logic erase_rise;

	// two flops before anything looks at the pins
	// the edge detect reads the second and third flops, never the first; the first may be metastable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			erase_m_q <= 1'b0;
			erase_s_q <= 1'b0;
			erase_d_q <= 1'b0;
			cmp_m_q <= 1'b0;
			cmp_s_q <= 1'b0;
		end else begin
			erase_m_q <= erase_btn_i;
			erase_s_q <= erase_m_q;
			erase_d_q <= erase_s_q;
			cmp_m_q <= cmp_gt_i;
			cmp_s_q <= cmp_m_q;
		end
	end
	assign erase_rise = erase_s_q & ~erase_d_q;

	// ************************************************************
	// completion timer
	// ************************************************************
	logic busy_q;
	vdisp_cmd_pkg::cnt_t count_q;
	logic done;

	// a new start overrides any pending delay, so no stale completion
	// done at count 1, not 0, so ready rises exactly n edges after the take
	assign done = busy_q & (count_q == vdisp_cmd_pkg::cnt_t'(1)) & ~start;

	// reload per command kind, count down to completion
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_q <= 1'b0;
			count_q <= '0;
		end else if (do_exec) begin
			busy_q <= 1'b1;
			count_q <= kind_cycles(acc[vdisp_cmd_pkg::KIND_LSB +: 2]);
		end else if (do_ldx | do_ldy) begin
			busy_q <= 1'b1;
			count_q <= vdisp_cmd_pkg::cnt_t'(XY_CYC);
		end else if (busy_q) begin
			count_q <= count_q - vdisp_cmd_pkg::cnt_t'(1);
			busy_q <= ~done;
		end
	end

	// ************************************************************
	// ready flag
	// ************************************************************
	logic ready_q;
	logic set_ev;
	logic clr_ev;

	assign set_ev = done | erase_rise;
	assign clr_ev = do_clr | start;

	// set beats clear so a completion is lost only to a new start, which masks done; converter load not here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ready_q <= vdisp_cmd_pkg::RST_READY;
		end else if (set_ev) begin
			ready_q <= 1'b1;
		end else if (clr_ev) begin
			ready_q <= 1'b0;
		end
	end

	// interrupt request follows the flag
	assign ready_irq_o = ready_q;

	// ************************************************************
	// analog side registers
	// ************************************************************
	// source select, converter and hold values, execute strobe
	// the two top accumulator bits carry no converter or hold data, so holds keep ten bits; the execute parameter keeps all twelve
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			src_sel_o <= vdisp_cmd_pkg::RST_SRC;
			dac_o <= vdisp_cmd_pkg::RST_DATA;
			x_hold_o <= vdisp_cmd_pkg::RST_DATA;
			y_hold_o <= vdisp_cmd_pkg::RST_DATA;
			exec_param_o <= vdisp_cmd_pkg::RST_PARAM;
			exec_start_o <= 1'b0;
		end else begin
			exec_start_o <= do_exec;
			if (do_sel) begin
				src_sel_o <= {acc[vdisp_cmd_pkg::SRC_BIT_HI], acc[vdisp_cmd_pkg::SRC_BIT_MID],
					acc[vdisp_cmd_pkg::SRC_BIT_LO]};
			end
			if (do_lda) begin
				dac_o <= acc[vdisp_cmd_pkg::DATA_W-1:0];
			end
			if (do_ldx) begin
				x_hold_o <= acc[vdisp_cmd_pkg::DATA_W-1:0];
			end
			if (do_ldy) begin
				y_hold_o <= acc[vdisp_cmd_pkg::DATA_W-1:0];
			end
			if (do_exec) begin
				exec_param_o <= acc;
			end
		end
	end

	// ************************************************************
	// bus answer
	// ************************************************************
	logic [31:0] rd_d;

	// skip reads return the test result in bit 0; unmapped reads give zero
	// status is a debug view; software needs only the two skip bits
	always_comb begin
		rd_d = 32'h0000_0000;
		case (wb_adr_i)
			vdisp_cmd_pkg::OFF_SKIP_READY: rd_d[0] = ready_q;
			vdisp_cmd_pkg::OFF_SKIP_COMPARE: rd_d[0] = cmp_s_q;
			vdisp_cmd_pkg::OFF_STATUS: begin
				rd_d[vdisp_cmd_pkg::ST_READY] = ready_q;
				rd_d[vdisp_cmd_pkg::ST_BUSY] = busy_q;
				rd_d[vdisp_cmd_pkg::ST_CMP] = cmp_s_q;
				rd_d[vdisp_cmd_pkg::ST_SRC_LSB +: 3] = src_sel_o;
				rd_d[vdisp_cmd_pkg::ST_DAC_LSB +: 10] = dac_o;
			end
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// one-cycle ack for every access, mapped or not
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= req;
			wb_dat_o <= (req & ~wb_we_i) ? rd_d : 32'h0000_0000;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_skip_ready: assert property (
		(req & ~wb_we_i & wb_adr_i == vdisp_cmd_pkg::OFF_SKIP_READY)
		|=> wb_ack_o && wb_dat_o[0] == $past(ready_q))
		else $error("skip-on-ready answer wrong");
	chk_irq_follow: assert property (
		$rose(ready_q) |-> ready_irq_o && $past(set_ev))
		else $error("ready rose without set event");
	chk_erase_sets: assert property (
		erase_rise |=> ready_q)
		else $error("erase button did not set ready");
	chk_clear_wins: assert property (
		(do_clr & ~set_ev) |=> !ready_q)
		else $error("clear command did not clear ready");
	chk_set_beats: assert property (
		(set_ev & clr_ev) |=> ready_q)
		else $error("set lost against clear");
	chk_start_clears: assert property (
		(start & ~erase_rise) |=> !ready_q ##1 busy_q)
		else $error("start did not clear ready");
	chk_lda_flags: assert property (
		(do_lda & ~set_ev) |=> $stable(ready_q) && dac_o == $past(acc[9:0]))
		else $error("converter load touched flags or missed data");
	chk_exec_reload: assert property (
		do_exec |=> busy_q && count_q == kind_cycles($past(acc[1:0])))
		else $error("execute delay loaded wrong");
	chk_xy_reload: assert property (
		(do_ldx | do_ldy) |=> count_q == vdisp_cmd_pkg::cnt_t'(XY_CYC))
		else $error("load delay wrong");
	chk_done_sets: assert property (
		done |=> ready_q && !busy_q)
		else $error("completion did not set ready");
	chk_src_pick: assert property (
		do_sel |=> src_sel_o == {$past(acc[9]), $past(acc[8]), $past(acc[5])})
		else $error("source select bits wrong");
	chk_cmp_skip: assert property (
		(req & ~wb_we_i & wb_adr_i == vdisp_cmd_pkg::OFF_SKIP_COMPARE)
		|=> wb_dat_o[0] == $past(cmp_s_q))
		else $error("compare skip answer wrong");

	// timer, flag and register bookkeeping
	chk_count_down: assert property (
		(busy_q & ~done & ~start) |=> busy_q && count_q == $past(count_q) - 27'h000_0001)
		else $error("completion counter did not step down");
	chk_idle_stays: assert property (
		(!busy_q & ~start) |=> !busy_q)
		else $error("timer started without a command");
	chk_no_stray_set: assert property (
		(!ready_q & ~set_ev) |=> !ready_q)
		else $error("ready set without an event");
	chk_other_writes: assert property (
		(wr_ok & ~start & ~do_clr & ~set_ev) |=> $stable(ready_q))
		else $error("non-flag write changed ready");
	chk_exec_strobe: assert property (
		do_exec |=> exec_start_o && exec_param_o == $past(acc))
		else $error("execute strobe or parameter wrong");
	chk_x_load: assert property (
		do_ldx |=> x_hold_o == $past(acc[9:0]))
		else $error("x hold value wrong");
	chk_y_load: assert property (
		do_ldy |=> y_hold_o == $past(acc[9:0]))
		else $error("y hold value wrong");
	chk_ack_pulse: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus answer not a single pulse");

	// covers for the main scenarios
	cov_xy_done: cover property ((do_ldx | do_ldy) ##1 busy_q [*2] ##[1:1000] done);
	cov_erase_btn: cover property (erase_rise ##1 ready_q);
	cov_restart: cover property (busy_q & start);
	cov_set_vs_clear: cover property (set_ev & clr_ev);
	cov_cmp_skip: cover property (do_lda ##[1:8]
		(req & ~wb_we_i & wb_adr_i == vdisp_cmd_pkg::OFF_SKIP_COMPARE));

endmodule : vdisp_cmd_unit

// File: src/vdisp_cmd_pkg.sv
// constants for the vector display command unit: command offsets, field
// positions, reset values and completion delays.
// assumes a 200 MHz system clock and a 32-bit classic wishbone register bus.
//
// Summary of operation
// - point or continue execute: ready after 20 us
// - short vector execute: ready after 250 us
// - long vector execute: ready after 4.05 ms
// - erase execute: ready after 500 ms
// - skip-on-ready answers skip exactly when ready
// - ready flag drives interrupt request
// - erase pushbutton sets ready flag
// - reset clears ready; x/y loads and execute clear it unless an erase press is detected in the same cycle
// - clear-ready command clears flag unless a set event comes in the same cycle
// - compare skip when converter exceeds source
// - converter load takes ten accumulator bits
// - converter load leaves all flags alone
// - x/y load: ready after 100 us
// - source select from accumulator bits 5,8,9
// - execute clears ready unless an erase press is detected in the same cycle, sets after delay
package vdisp_cmd_pkg;

	// ************************************************************
	// register offsets, byte addresses of aligned words
	// ************************************************************
	localparam logic [7:0] OFF_SELECT_SRC = 8'h00;
	localparam logic [7:0] OFF_LOAD_X = 8'h04;
	localparam logic [7:0] OFF_LOAD_Y = 8'h08;
	localparam logic [7:0] OFF_EXECUTE = 8'h0C;
	localparam logic [7:0] OFF_SKIP_READY = 8'h10;
	localparam logic [7:0] OFF_CLEAR_READY = 8'h14;
	localparam logic [7:0] OFF_SKIP_COMPARE = 8'h18;
	localparam logic [7:0] OFF_LOAD_CONV = 8'h1C;
	localparam logic [7:0] OFF_STATUS = 8'h20;

	// ************************************************************
	// field positions in the 12-bit accumulator word (bit 0 = lsb)
	// ************************************************************
	localparam int unsigned ACC_W = 12;
	localparam int unsigned DATA_W = 10;
	localparam int unsigned SRC_BIT_HI = 9;
	localparam int unsigned SRC_BIT_MID = 8;
	localparam int unsigned SRC_BIT_LO = 5;
	localparam int unsigned KIND_LSB = 0;

	// ************************************************************
	// status word positions
	// ************************************************************
	localparam int unsigned ST_READY = 0;
	localparam int unsigned ST_BUSY = 1;
	localparam int unsigned ST_CMP = 2;
	localparam int unsigned ST_SRC_LSB = 4;
	localparam int unsigned ST_DAC_LSB = 8;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic RST_READY = 1'b0;
	localparam logic [2:0] RST_SRC = 3'h0;
	localparam logic [9:0] RST_DATA = 10'h000;
	localparam logic [11:0] RST_PARAM = 12'h000;

	// execute operation kinds taken from the parameter word
	typedef enum logic [1:0] {
		KIND_POINT,
		KIND_SHORT,
		KIND_LONG,
		KIND_ERASE
	} exec_kind_t;

	// ************************************************************
	// completion delays
	// ************************************************************
	localparam int unsigned CNT_W = 27;
	typedef logic [26:0] cnt_t;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned T_POINT_US = 20;
	localparam int unsigned T_XY_US = 100;
	localparam int unsigned T_SHORT_US = 250;
	localparam real T_LONG_MS = 4.05;
	localparam int unsigned T_ERASE_MS = 500;
	localparam int unsigned POINT_CYCLES = T_POINT_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned XY_CYCLES = T_XY_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned SHORT_CYCLES = T_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned LONG_CYCLES = int'(T_LONG_MS * 1.0e6 / CLK_PERIOD_NS);
	localparam int unsigned ERASE_CYCLES = T_ERASE_MS * 1000000 / CLK_PERIOD_NS;

endpackage : vdisp_cmd_pkg

// File: dv/host_cpu_model.sv
// host processor model: issues io transfer instructions as classic
// wishbone single cycles toward the command unit.
// assumes a registered ack that is held for exactly one cycle.
`timescale 1ns/1ps

module host_cpu_model (
	// clock
	input wire logic clk_i,
	// wishbone master
	output logic cyc_o,
	output logic stb_o,
	output logic we_o,
	output logic [7:0] adr_o,
	output logic [3:0] sel_o,
	output logic [31:0] dat_o,
	input wire logic ack_i,
	input wire logic [31:0] dat_i
);
	// idle bus; released data carries a toggling pattern, not the last word
	initial begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'h0;
		dat_o = 32'h0000_0000;
	end

	// one cycle; hold everything until the edge that samples ack high
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o <= w;
		adr_o <= a;
		sel_o <= 4'hf;
		dat_o <= d;
		do begin
			@(posedge clk_i);
		end while (ack_i !== 1'b1);
		q = dat_i; // taken at the same edge that sees ack high
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		we_o <= 1'b0;
		dat_o <= ~d;
	endtask : xfer
endmodule : host_cpu_model

// File: dv/vector_display_io_command_unit_tb.sv
// self-checking bench for the command unit, small delay parameters.
// assumes the host model above as the only bus master.
`timescale 1ns/1ps

module vector_display_io_command_unit_tb;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic clk_i, rst_i, erase_btn_i, cmp_gt_i, cyc, stb, we, ack, irq, start;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [2:0] src;
	logic [9:0] dac, xh, yh;
	logic [11:0] prm;
	logic [9:0] target;
	int fails, n_compared;
	int kn[4] = '{vdisp_cmd_pkg::POINT_CYCLES, 30, 40, 50};

	host_cpu_model i_host (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
		.sel_o(sel), .dat_o(wdat), .ack_i(ack), .dat_i(rdat));
	vdisp_cmd_unit #(.XY_CYC(20), .SHORT_CYC(30), .LONG_CYC(40), .ERASE_CYC(50)) i_dut (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.erase_btn_i(erase_btn_i), .cmp_gt_i(cmp_gt_i), .ready_irq_o(irq),
		.src_sel_o(src), .dac_o(dac), .x_hold_o(xh), .y_hold_o(yh),
		.exec_param_o(prm), .exec_start_o(start));

	// clock, and the analog comparator against a fixed source level
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	always_ff @(posedge clk_i) cmp_gt_i <= (dac > target);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		i_host.xfer(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		i_host.xfer(1'b0, a, 32'h0000_0000, q);
	endtask : rd

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	// ************************************************************
	// scenarios
	// ************************************************************
	// command clears ready, ready returns n cycles after the taking edge
	task automatic t_delay(input logic [7:0] a, input logic [31:0] d, input int n);
		int cnt;
		logic [31:0] q;
		wr(a, d);
		check("exec strobe", {31'd0, start}, {31'd0, a == vdisp_cmd_pkg::OFF_EXECUTE});
		#1;
		check("strobe dropped", {31'd0, start}, 32'd0);
		check("ready cleared", {31'd0, irq}, 32'd0);
		rd(vdisp_cmd_pkg::OFF_SKIP_READY, q);
		check("skip while busy", q & 32'd1, 32'd0);
		cnt = 3;
		while (irq !== 1'b1 && cnt < n + 10) begin
			@(posedge clk_i);
			#1;
			cnt++;
		end
		check("ready delay", cnt, n - 1);
		rd(vdisp_cmd_pkg::OFF_SKIP_READY, q);
		check("skip when ready", q & 32'd1, 32'd1);
	endtask : t_delay

	task automatic t_exec_kinds;
		for (int k = 0; k < 4; k++) begin
			t_delay(vdisp_cmd_pkg::OFF_EXECUTE, 32'h0000_0a40 | k, kn[k]);
			check("exec param", {20'd0, prm}, 32'h0000_0a40 | k);
		end
		t_delay(vdisp_cmd_pkg::OFF_LOAD_X, 32'h0000_0f5a, 20);
		check("x hold", {22'd0, xh}, 32'h0000_035a);
		t_delay(vdisp_cmd_pkg::OFF_LOAD_Y, 32'h0000_0c21, 20);
		check("y hold", {22'd0, yh}, 32'h0000_0021);
	endtask : t_exec_kinds

	// a long execute is abandoned by a load issued right behind it
	task automatic t_abandon;
		wr(vdisp_cmd_pkg::OFF_EXECUTE, 32'h0000_0002);
		t_delay(vdisp_cmd_pkg::OFF_LOAD_X, 32'h0000_0001, 20);
		wr(vdisp_cmd_pkg::OFF_CLEAR_READY, 32'h0000_0000);
		repeat (40) @(posedge clk_i);
		#1;
		check("no late ready", {31'd0, irq}, 32'd0);
	endtask : t_abandon

	task automatic t_sources;
		logic [2:0] c[6] = '{3'd0, 3'd1, 3'd4, 3'd5, 3'd6, 3'd7};
		for (int i = 0; i < 6; i++) begin
			wr(vdisp_cmd_pkg::OFF_SELECT_SRC, {22'd0, c[i][2], c[i][1], 2'b00, c[i][0], 5'h1f});
			check("source", {29'd0, src}, {29'd0, c[i]});
		end
	endtask : t_sources

	// successive approximation with ready left set throughout
	task automatic t_convert;
		logic [9:0] res;
		logic [31:0] q;
		res = 10'h000;
		for (int b = 9; b >= 0; b--) begin
			wr(vdisp_cmd_pkg::OFF_LOAD_CONV, {22'h3f_fc00, res | (10'h001 << b)});
			check("dac", {22'd0, dac}, {22'd0, res | (10'h001 << b)});
			repeat (4) @(posedge clk_i);
			rd(vdisp_cmd_pkg::OFF_SKIP_COMPARE, q);
			if (q[0] === 1'b0)
				res = res | (10'h001 << b);
		end
		check("convert result", {22'd0, res}, {22'd0, target});
		check("ready kept", {31'd0, irq}, 32'd1);
	endtask : t_convert

	task automatic t_erase_and_misc;
		logic [31:0] q;
		// press twice; the clear in between must drop a flag that is really set
		for (int i = 0; i < 2; i++) begin
			@(posedge clk_i);
			erase_btn_i <= 1'b1;
			repeat (8) @(posedge clk_i);
			check("erase sets ready", {31'd0, irq}, 32'd1);
			erase_btn_i <= 1'b0;
			if (i == 0) begin
				wr(vdisp_cmd_pkg::OFF_CLEAR_READY, 32'hffff_ffff);
				check("cleared", {31'd0, irq}, 32'd0);
			end
		end
		rd(8'h3c, q);
		check("unmapped read", q, 32'd0);
	endtask : t_erase_and_misc

	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		fails = 0;
		n_compared = 0;
		rst_i = 1'b1;
		erase_btn_i = 1'b0;
		target = 10'h2a5;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check("reset ready", {31'd0, irq}, 32'd0);
		check("reset dac", {22'd0, dac}, 32'd0);
		t_exec_kinds();
		t_abandon();
		t_sources();
		t_erase_and_misc();
		t_convert();
		// a reset in mid-run drops the flag and the converter value
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check("run reset ready", {31'd0, irq}, 32'd0);
		check("run reset dac", {22'd0, dac}, 32'd0);
		end_sim();
	end

	initial begin
		#150000;
		fails++;
		end_sim();
	end
endmodule : vector_display_io_command_unit_tb
